// file: design/vout_target_command_regs.sv
// Summary of operation
// - Alert mask bits 3..1 gate vendor events
// - Brief sync alert at stack enable tolerated
// - Masked events still set their status bits
// - Format is one byte, byte read/write
// - Format writable only with conversion disabled
// - Format bit 7 stored and read back; no relative data mode
// - Format bits 6:5 read zero, unwritable
// - Exponent bits 4:0, -4 to -12 supported
// - Format change rescales setpoint and offset, not boot default
// - Writes use format in force at write
// - Setpoint word sets target, ramps at rate
// - Reset pin restores boot voltage to setpoint
// - Power-on/restore loads NVM or strap default
// - Boot default kept apart from live setpoint
// - Fault shutdown keeps or reloads setpoint
// - Limit violation clamps reference; warns only while conversion enabled
// - Offset word is signed, added to setpoint
// - Offset backup eight bits, saturated, exponent -12
// - Above DAC maximum clamps without warning
`timescale 1ns/1ps
`default_nettype none
module vout_target_command_regs import vout_regs_pkg::*; (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        smb_clk_pin,
	input  wire logic        smb_data_in,
	output logic             smb_data_out,
	output logic             smb_data_oe,
	output logic             smb_alert_out,
	output logic             smb_alert_oe,
	input  wire logic        power_good_or_reset_pin,
	input  wire logic        pgood_pin_is_reset,
	input  wire logic        fault_restore_select,
	input  wire logic        strap_source_select,
	input  wire logic [15:0] voltage_select_strap,
	input  wire logic [7:0]  nvm_format,
	input  wire logic [15:0] nvm_setpoint,
	input  wire logic [7:0]  nvm_trim,
	input  wire logic [7:0]  nvm_alert_mask,
	input  wire logic        restore_user_all,
	input  wire logic        conversion_enabled,
	input  wire logic        fault_shutdown,
	input  wire logic        margin_active,
	input  wire logic [15:0] margin_setpoint,
	input  wire logic [15:0] vout_max,
	input  wire logic [15:0] vout_min,
	input  wire logic        reset_event,
	input  wire logic        backchannel_event,
	input  wire logic        sync_event,
	input  wire logic        clear_status,
	output logic [23:0]      dac_reference,
	output logic [7:0]       vendor_status_byte,
	output logic             vout_limit_warning,
	output logic [7:0]       trim_backup
);
	smbus_byte_if link ();

	smbus_byte_engine u_engine (
		.clk     (clk),
		.reset_n (reset_n),
		.scl_pin (smb_clk_pin),
		.sda_in  (smb_data_in),
		.sda_oe  (smb_data_oe),
		.link    (link)
	);

	function automatic logic [3:0] shift_of(input logic [4:0] e);
		logic [4:0] s;
		s = e + EXP_BIAS;
		return s[3:0];
	endfunction

	function automatic logic exp_ok(input logic [4:0] e);
		return ($signed(e) >= $signed(EXP_LEAST)) && ($signed(e) <= $signed(EXP_MOST));
	endfunction

	function automatic wide_t scale_u(input logic [15:0] v, input logic [3:0] sh);
		return wide_t'({10'h000, v}) <<< sh;
	endfunction

	function automatic wide_t scale_s(input logic [15:0] v, input logic [3:0] sh);
		return wide_t'({{10{v[15]}}, v}) <<< sh;
	endfunction

	logic        load_reg, load_next;
	logic        pg_meta_reg, pg_sync_reg;
	logic [7:0]  fmt_reg, fmt_next;
	logic [15:0] setpoint_reg, setpoint_next;
	logic [15:0] trim_reg, trim_next;
	logic [15:0] boot_reg, boot_next;
	logic [7:0]  mask_reg, mask_next;
	logic [7:0]  status_reg, status_next;
	logic        minmax_reg, minmax_next;
	logic        alert_reg, alert_next;
	logic [23:0] ref_reg, ref_next;
	logic [7:0]  timer_reg, timer_next;
	logic [7:0]  backup_reg, backup_next;
	phase_t      phase_reg, phase_next;
	logic [7:0]  cmd_reg, cmd_next;
	logic [7:0]  lo_reg, lo_next, hi_reg, hi_next;
	logic [1:0]  nbytes_reg, nbytes_next;
	logic        wr_reg, wr_next, ack_reg, ack_next, txm_reg, txm_next;
	logic        rd_idx_reg, rd_idx_next;
	logic [7:0]  txd_reg, txd_next;

	logic [3:0]  sh, new_sh, load_sh;
	logic [15:0] active;
	wide_t       trim_int, sum, hi_lim, lo_lim, clamp, conv;
	logic        over, under, exec, pin_reset, reload;
	logic [7:0]  new_fmt, rd_byte;
	logic [15:0] rd_word;

	always_comb begin
		load_next     = 1'b0;
		fmt_next      = fmt_reg;
		setpoint_next = setpoint_reg;
		trim_next     = trim_reg;
		boot_next     = boot_reg;
		mask_next     = mask_reg;
		phase_next    = phase_reg;
		cmd_next      = cmd_reg;
		lo_next       = lo_reg;
		hi_next       = hi_reg;
		nbytes_next   = nbytes_reg;
		wr_next       = wr_reg;
		ack_next      = ack_reg;
		txm_next      = txm_reg;
		rd_idx_next   = rd_idx_reg;
		txd_next      = txd_reg;

		// Setpoint or margin plus offset, in the finest internal unit
		sh       = shift_of(fmt_reg[FMT_EXP_HI:0]);
		active   = margin_active ? margin_setpoint : setpoint_reg;
		trim_int = scale_s(trim_reg, sh);
		sum      = scale_u(active, sh) + trim_int;
		hi_lim   = scale_u(vout_max, sh);
		lo_lim   = scale_u(vout_min, sh);
		over     = sum > hi_lim;
		under    = sum < lo_lim;
		if (over) begin
			clamp = hi_lim;
		end else if (under) begin
			clamp = lo_lim;
		end else begin
			clamp = sum;
		end
		// DAC ceiling applies after the limits, before the zero floor, and raises no warning
		if (clamp > DAC_MAX_W) begin
			clamp = DAC_MAX_W;
		end
		if (clamp < WIDE_ZERO) begin
			clamp = WIDE_ZERO;
		end

		// One LSB per step keeps the slew bounded
		ref_next   = ref_reg;
		timer_next = timer_reg - 8'h01;
		if (timer_reg == 8'h00) begin
			timer_next = RAMP_RELOAD;
			if (ref_reg < clamp[23:0]) begin
				ref_next = ref_reg + 24'h00_0001;
			end else if (ref_reg > clamp[23:0]) begin
				ref_next = ref_reg - 24'h00_0001;
			end
		end

		// Status is set regardless of mask; set wins over clear
		status_next = clear_status ? 8'h00 : status_reg;
		status_next[EV_RESET_BIT] = status_next[EV_RESET_BIT] | reset_event;
		status_next[EV_BCX_BIT]   = status_next[EV_BCX_BIT] | backchannel_event;
		status_next[EV_SYNC_BIT]  = status_next[EV_SYNC_BIT] | sync_event;
		minmax_next = (minmax_reg & ~clear_status) | (conversion_enabled & (over | under));
		// A stack enable may flash the sync event through here
		alert_next = (|(status_reg & ~mask_reg & ALERT_MASK_BITS)) | minmax_reg;

		if (trim_int > TRIM_SAT_HI) begin
			backup_next = TRIM_SAT_HI[7:0];
		end else if (trim_int < TRIM_SAT_LO) begin
			backup_next = TRIM_SAT_LO[7:0];
		end else begin
			backup_next = trim_int[7:0];
		end

		// Read data for the current command
		case (cmd_reg)
			CMD_FORMAT:     rd_word = {8'h00, fmt_reg};
			CMD_SETPOINT:   rd_word = setpoint_reg;
			CMD_OFFSET:     rd_word = trim_reg;
			CMD_ALERT_MASK: rd_word = {8'h00, mask_reg};
			default:        rd_word = {UNMAPPED_READ, UNMAPPED_READ};
		endcase
		rd_byte = rd_idx_reg ? rd_word[15:8] : rd_word[7:0];

		// Transaction tracking
		exec = link.stop && wr_reg && (phase_reg == PH_DATA);
		if (link.start) begin
			phase_next = PH_ADDR;
			ack_next   = 1'b0;
			txm_next   = 1'b0;
		end else if (link.stop) begin
			phase_next = PH_IDLE;
			wr_next    = 1'b0;
			ack_next   = 1'b0;
			txm_next   = 1'b0;
		end else if (link.rx_valid) begin
			case (phase_reg)
				PH_ADDR: begin
					if (link.rx_data[7:1] == DEV_ADDR) begin
						ack_next = 1'b1;
						if (link.rx_data[0]) begin
							txm_next    = 1'b1;
							// Our own address ack raises tx_done, which loads the low byte
							rd_idx_next = 1'b0;
							txd_next    = rd_word[7:0];
							phase_next  = PH_IDLE;
						end else begin
							wr_next    = 1'b1;
							phase_next = PH_CMD;
						end
					end else begin
						ack_next   = 1'b0;
						phase_next = PH_IDLE;
					end
				end
				PH_CMD: begin
					cmd_next    = link.rx_data;
					nbytes_next = 2'b00;
					ack_next    = 1'b1;
					phase_next  = PH_DATA;
				end
				PH_DATA: begin
					if (nbytes_reg == 2'b00) begin
						lo_next = link.rx_data;
					end else if (nbytes_reg == 2'b01) begin
						hi_next = link.rx_data;
					end
					if (nbytes_reg != 2'b11) begin
						nbytes_next = nbytes_reg + 2'b01;
					end
					ack_next = 1'b1;
				end
				default: begin
					ack_next = 1'b0;
				end
			endcase
		end else if (link.tx_done) begin
			ack_next = 1'b0;
			if (link.master_ack) begin
				txd_next    = rd_byte;
				rd_idx_next = ~rd_idx_reg;
			end else begin
				txm_next = 1'b0;
			end
		end

		// Host writes, decoded with the format in force now
		new_fmt = (lo_reg & FMT_WRITABLE);
		new_sh  = shift_of(new_fmt[FMT_EXP_HI:0]);
		conv    = WIDE_ZERO;
		if (exec) begin
			case (cmd_reg)
				CMD_FORMAT: begin
					if (nbytes_reg == 2'b01 && !conversion_enabled
						&& exp_ok(new_fmt[FMT_EXP_HI:0])) begin
						fmt_next      = new_fmt;
						conv          = scale_u(setpoint_reg, sh) >>> new_sh;
						setpoint_next = conv[15:0];
						conv          = trim_int >>> new_sh;
						trim_next     = conv[15:0];
					end
				end
				CMD_SETPOINT: begin
					if (nbytes_reg == 2'b10) begin
						setpoint_next = {hi_reg, lo_reg};
					end
				end
				CMD_OFFSET: begin
					if (nbytes_reg == 2'b10) begin
						trim_next = {hi_reg, lo_reg};
					end
				end
				CMD_ALERT_MASK: begin
					if (nbytes_reg == 2'b10 && lo_reg == ALERT_MASK_SEL) begin
						mask_next = hi_reg & ALERT_MASK_BITS;
					end
				end
				default: begin
					mask_next = mask_reg;
				end
			endcase
		end

		reload = fault_shutdown && fault_restore_select;
		if (reload) begin
			setpoint_next = boot_reg;
		end
		pin_reset = pgood_pin_is_reset && !pg_sync_reg;
		if (pin_reset) begin
			setpoint_next = boot_reg;
		end

		// Defaults arrive after reset release, never under it
		load_sh = shift_of(nvm_format[FMT_EXP_HI:0]);
		if (load_reg || restore_user_all) begin
			fmt_next      = nvm_format & FMT_WRITABLE;
			mask_next     = nvm_alert_mask & ALERT_MASK_BITS;
			boot_next     = strap_source_select ? voltage_select_strap : nvm_setpoint;
			setpoint_next = boot_next;
			conv          = wide_t'({{18{nvm_trim[7]}}, nvm_trim}) >>> load_sh;
			trim_next     = conv[15:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			load_reg     <= 1'b1;
			pg_meta_reg  <= 1'b1;
			pg_sync_reg  <= 1'b1;
			fmt_reg      <= 8'h00;
			setpoint_reg <= 16'h0000;
			trim_reg     <= 16'h0000;
			boot_reg     <= 16'h0000;
			mask_reg     <= 8'h00;
			status_reg   <= 8'h00;
			minmax_reg   <= 1'b0;
			alert_reg    <= 1'b0;
			ref_reg      <= 24'h00_0000;
			timer_reg    <= 8'h00;
			backup_reg   <= 8'h00;
			phase_reg    <= PH_IDLE;
			cmd_reg      <= 8'h00;
			lo_reg       <= 8'h00;
			hi_reg       <= 8'h00;
			nbytes_reg   <= 2'b00;
			wr_reg       <= 1'b0;
			ack_reg      <= 1'b0;
			txm_reg      <= 1'b0;
			rd_idx_reg   <= 1'b0;
			txd_reg      <= 8'h00;
		end else begin
			load_reg     <= load_next;
			pg_meta_reg  <= power_good_or_reset_pin;
			pg_sync_reg  <= pg_meta_reg;
			fmt_reg      <= fmt_next;
			setpoint_reg <= setpoint_next;
			trim_reg     <= trim_next;
			boot_reg     <= boot_next;
			mask_reg     <= mask_next;
			status_reg   <= status_next;
			minmax_reg   <= minmax_next;
			alert_reg    <= alert_next;
			ref_reg      <= ref_next;
			timer_reg    <= timer_next;
			backup_reg   <= backup_next;
			phase_reg    <= phase_next;
			cmd_reg      <= cmd_next;
			lo_reg       <= lo_next;
			hi_reg       <= hi_next;
			nbytes_reg   <= nbytes_next;
			wr_reg       <= wr_next;
			ack_reg      <= ack_next;
			txm_reg      <= txm_next;
			rd_idx_reg   <= rd_idx_next;
			txd_reg      <= txd_next;
		end
	end

	assign link.ack_req       = ack_reg;
	assign link.tx_mode       = txm_reg;
	assign link.tx_data       = txd_reg;
	assign smb_data_out       = 1'b0;
	assign smb_alert_out      = 1'b0;
	assign smb_alert_oe       = alert_reg;
	assign dac_reference      = ref_reg;
	assign vendor_status_byte = status_reg;
	assign vout_limit_warning = minmax_reg;
	assign trim_backup        = backup_reg;

	a_format_locked: assert property (@(posedge clk) disable iff (!reset_n)
		conversion_enabled && !load_reg && !restore_user_all |=> $stable(fmt_reg))
		else $error("format byte changed while conversion enabled");
	a_mode_zero: assert property (@(posedge clk) disable iff (!reset_n)
		fmt_reg[6:5] == 2'b00)
		else $error("format mode field not zero");
	a_pin_boot: assert property (@(posedge clk) disable iff (!reset_n)
		pin_reset && !load_reg && !restore_user_all |=> setpoint_reg == $past(boot_reg))
		else $error("reset pin did not restore boot voltage");
	a_boot_kept: assert property (@(posedge clk) disable iff (!reset_n)
		!load_reg && !restore_user_all |=> $stable(boot_reg))
		else $error("boot default overwritten");
	a_fault_keep: assert property (@(posedge clk) disable iff (!reset_n)
		fault_shutdown && !fault_restore_select && !exec && !pin_reset && !load_reg
		&& !restore_user_all |=> $stable(setpoint_reg))
		else $error("setpoint lost across fault");
	a_alert_gate: assert property (@(posedge clk) disable iff (!reset_n)
		##1 alert_reg == ($past(minmax_reg)
		|| (|($past(status_reg) & ~$past(mask_reg) & ALERT_MASK_BITS))))
		else $error("alert does not follow masked status");
	a_status_set: assert property (@(posedge clk) disable iff (!reset_n)
		reset_event |=> status_reg[EV_RESET_BIT])
		else $error("masked event did not set status");
	a_dac_ceiling: assert property (@(posedge clk) disable iff (!reset_n)
		ref_reg <= DAC_MAX_W[23:0])
		else $error("reference above DAC maximum");
	a_ramp_step: assert property (@(posedge clk) disable iff (!reset_n)
		ref_reg != $past(ref_reg) |-> $past(timer_reg) == 8'h00
		&& (ref_reg - $past(ref_reg) == 24'h00_0001 || $past(ref_reg) - ref_reg == 24'h00_0001))
		else $error("reference stepped off schedule");
endmodule
`default_nettype wire

// file: design/vout_regs_pkg.sv
package vout_regs_pkg;
	// Command codes on the management link
	localparam logic [7:0] CMD_FORMAT     = 8'h20;
	localparam logic [7:0] CMD_SETPOINT   = 8'h21;
	localparam logic [7:0] CMD_OFFSET     = 8'h22;
	localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
	localparam logic [7:0] ALERT_MASK_SEL = 8'h80;
	localparam logic [7:0] UNMAPPED_READ  = 8'h00;

	// Target address, arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h24;

	// Format byte layout
	localparam int         FMT_REL_BIT  = 7;
	localparam int         FMT_EXP_HI   = 4;
	localparam logic [7:0] FMT_WRITABLE = 8'h9F;
	localparam logic [4:0] EXP_MOST     = 5'h1C;
	localparam logic [4:0] EXP_LEAST    = 5'h14;
	localparam logic [4:0] EXP_BIAS     = 5'h0C;

	// Vendor alert mask and status layout
	localparam logic [7:0] ALERT_MASK_BITS = 8'h0E;
	localparam int         EV_RESET_BIT    = 3;
	localparam int         EV_BCX_BIT      = 2;
	localparam int         EV_SYNC_BIT     = 1;

	// Internal voltage unit is the finest exponent
	typedef logic signed [25:0] wide_t;
	localparam wide_t      DAC_MAX_W   = 26'sh000_3999;
	localparam wide_t      TRIM_SAT_HI = 26'sh000_007F;
	localparam wide_t      TRIM_SAT_LO = -26'sh000_0080;
	localparam wide_t      WIDE_ZERO   = 26'sh000_0000;

	// Reference ramp timing
	localparam int         CLK_PERIOD_NS    = 10;
	localparam int         RAMP_STEP_NS     = 100;
	localparam int         RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] RAMP_RELOAD      = 8'(RAMP_STEP_CYCLES - 1);

	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT      = 4'h8;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ADDR = 2'b01,
		PH_CMD  = 2'b10,
		PH_DATA = 2'b11
	} phase_t;
endpackage

// file: design/smbus_byte_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smbus_byte_if;
	logic       start;
	logic       stop;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       tx_done;
	logic       master_ack;
	logic       ack_req;
	logic       tx_mode;
	logic [7:0] tx_data;

	modport engine (
		output start, stop, rx_valid, rx_data, tx_done, master_ack,
		input  ack_req, tx_mode, tx_data
	);
	modport ctrl (
		input  start, stop, rx_valid, rx_data, tx_done, master_ack,
		output ack_req, tx_mode, tx_data
	);
endinterface
`default_nettype wire

// file: design/smbus_byte_engine.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_byte_engine import vout_regs_pkg::*; (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        scl_pin,
	input  wire logic        sda_in,
	output logic             sda_oe,
	smbus_byte_if.engine     link
);
	logic       scl_meta_reg, scl_sync_reg, scl_prev_reg;
	logic       sda_meta_reg, sda_sync_reg, sda_prev_reg;
	logic       busy_reg, busy_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic       oe_reg, oe_next;
	logic       start_reg, start_next, stop_reg, stop_next;
	logic       rxv_reg, rxv_next, txd_reg, txd_next;
	logic       mack_reg, mack_next;
	logic       scl_rise, scl_fall, start_cond, stop_cond;

	always_comb begin
		scl_rise   = scl_sync_reg & ~scl_prev_reg;
		scl_fall   = ~scl_sync_reg & scl_prev_reg;
		start_cond = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
		stop_cond  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
		busy_next  = busy_reg;
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		oe_next    = oe_reg;
		start_next = 1'b0;
		stop_next  = 1'b0;
		rxv_next   = 1'b0;
		txd_next   = 1'b0;
		mack_next  = mack_reg;
		if (start_cond) begin
			busy_next  = 1'b1;
			cnt_next   = '0;
			oe_next    = 1'b0;
			start_next = 1'b1;
		end else if (stop_cond) begin
			busy_next = 1'b0;
			oe_next   = 1'b0;
			stop_next = 1'b1;
		end else if (busy_reg && scl_rise) begin
			if (cnt_reg < ACK_SLOT) begin
				shift_next = {shift_reg[6:0], sda_sync_reg};
				cnt_next   = cnt_reg + 4'h1;
				rxv_next   = (cnt_reg == LAST_DATA_BIT) && !link.tx_mode;
			end else begin
				cnt_next  = '0;
				txd_next  = link.tx_mode;
				mack_next = ~sda_sync_reg;
			end
		end else if (busy_reg && scl_fall) begin
			// Data and ack change only while the clock is low
			if (cnt_reg < ACK_SLOT) begin
				oe_next = link.tx_mode && !link.tx_data[~cnt_reg[2:0]];
			end else begin
				oe_next = link.ack_req;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			busy_reg     <= 1'b0;
			cnt_reg      <= '0;
			shift_reg    <= '0;
			oe_reg       <= 1'b0;
			start_reg    <= 1'b0;
			stop_reg     <= 1'b0;
			rxv_reg      <= 1'b0;
			txd_reg      <= 1'b0;
			mack_reg     <= 1'b0;
		end else begin
			scl_meta_reg <= scl_pin;
			scl_sync_reg <= scl_meta_reg;
			scl_prev_reg <= scl_sync_reg;
			sda_meta_reg <= sda_in;
			sda_sync_reg <= sda_meta_reg;
			sda_prev_reg <= sda_sync_reg;
			busy_reg     <= busy_next;
			cnt_reg      <= cnt_next;
			shift_reg    <= shift_next;
			oe_reg       <= oe_next;
			start_reg    <= start_next;
			stop_reg     <= stop_next;
			rxv_reg      <= rxv_next;
			txd_reg      <= txd_next;
			mack_reg     <= mack_next;
		end
	end

	assign sda_oe          = oe_reg;
	assign link.start      = start_reg;
	assign link.stop       = stop_reg;
	assign link.rx_valid   = rxv_reg;
	assign link.rx_data    = shift_reg;
	assign link.tx_done    = txd_reg;
	assign link.master_ack = mack_reg;
endmodule
`default_nettype wire

// file: test/smbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model import vout_regs_pkg::*; (
	output logic     scl,
	output logic     sda_low,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// SDA moves only mid-low, so the target's sync delay never sees it near SCL rise
	task automatic bit_io(input logic b, output logic s);
		scl = 1'b0;
		#31.25 sda_low = ~b;
		#31.25 scl = 1'b1;
		#31.25 s = sda;
		#31.25;
	endtask
	// Start when stp is 0, stop when 1; clock then idles high
	task automatic frame(input logic stp);
		scl = 1'b0;
		#31.25 sda_low = stp;
		#31.25 scl = 1'b1;
		#31.25 sda_low = ~stp;
		#31.25;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] o,
			output logic k);
		for (int i = 7; i >= 0; i--) bit_io(d[i], o[i]);
		bit_io(m, k);
	endtask
	task automatic xfer(input logic [7:0] cmd, input int wn, input logic [15:0] wd,
			input int rn, output logic [15:0] rd, output logic ok);
		logic [7:0] o;
		logic       k;
		ok = 1'b1;
		rd = 16'h0000;
		frame(1'b0);
		byte_io({DEV_ADDR, 1'b0}, 1'b1, o, k);
		ok &= ~k;
		byte_io(cmd, 1'b1, o, k);
		ok &= ~k;
		for (int i = 0; i < wn; i++) begin
			byte_io(wd[8*i +: 8], 1'b1, o, k);
			ok &= ~k;
		end
		if (rn > 0) begin
			frame(1'b0);
			byte_io({DEV_ADDR, 1'b1}, 1'b1, o, k);
			ok &= ~k;
			for (int i = 0; i < rn; i++) begin
				byte_io(8'hFF, i == rn - 1, o, k);
				rd[8*i +: 8] = o;
			end
		end
		frame(1'b1);
	endtask
endmodule
`default_nettype wire

// file: test/tb_vout_target_command_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_vout_target_command_regs import vout_regs_pkg::*; ;
	typedef struct packed {
		logic [7:0] cmd; logic [1:0] wn; logic [15:0] wd; logic [1:0] rn; logic [15:0] ex;
	} row_t;
	logic        clk, reset_n, smb_clk_pin, sda_low, smb_data_oe, smb_alert_oe, ok;
	logic        power_good_or_reset_pin, pgood_pin_is_reset, fault_restore_select;
	logic        strap_source_select, restore_user_all, conversion_enabled, fault_shutdown;
	logic        margin_active, reset_event, backchannel_event, sync_event, clear_status;
	logic        vout_limit_warning;
	logic [7:0]  nvm_format, nvm_trim, nvm_alert_mask, vendor_status_byte, trim_backup;
	logic [15:0] voltage_select_strap, nvm_setpoint, margin_setpoint, vout_max, vout_min, rd;
	logic [23:0] dac_reference;
	wire logic   smb_data_in;
	int          bad_count, cmp_count;
	row_t rows [8] = '{
		'{CMD_FORMAT, 2'd1, 16'h00F4, 2'd1, 16'h0094},
		'{CMD_FORMAT, 2'd1, 16'h009F, 2'd1, 16'h0094},
		'{CMD_FORMAT, 2'd1, 16'h001C, 2'd1, 16'h001C},
		'{CMD_FORMAT, 2'd1, 16'h0014, 2'd1, 16'h0014},
		'{CMD_SETPOINT, 2'd2, 16'h1234, 2'd2, 16'h1234},
		'{CMD_OFFSET, 2'd2, 16'hFFF0, 2'd2, 16'hFFF0},
		'{CMD_ALERT_MASK, 2'd2, 16'hFF80, 2'd1, 16'h000E},
		'{8'h55, 2'd1, 16'h0012, 2'd1, 16'h0000}
	};
	// Open-drain data line with pull-up
	assign smb_data_in = ~(sda_low | smb_data_oe);
	smbus_host_model host_i (.scl(smb_clk_pin), .sda_low, .sda(smb_data_in));
	vout_target_command_regs vout_target_command_regs_i (
		.clk, .reset_n, .smb_clk_pin, .smb_data_in, .smb_data_out(), .smb_data_oe,
		.smb_alert_out(), .smb_alert_oe, .power_good_or_reset_pin, .pgood_pin_is_reset,
		.fault_restore_select, .strap_source_select, .voltage_select_strap, .nvm_format,
		.nvm_setpoint, .nvm_trim, .nvm_alert_mask, .restore_user_all, .conversion_enabled,
		.fault_shutdown, .margin_active, .margin_setpoint, .vout_max, .vout_min,
		.reset_event, .backchannel_event, .sync_event, .clear_status, .dac_reference,
		.vendor_status_byte, .vout_limit_warning, .trim_backup);
	task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
		host_i.xfer(c, n, d, 0, rd, ok);
		// Writes land a few cycles after the stop edge
		repeat (5) @(negedge clk);
	endtask
	task automatic rdc(input string nm, input logic [7:0] c, input int n, input logic [15:0] e);
		host_i.xfer(c, 0, 16'h0000, n, rd, ok);
		repeat (5) @(negedge clk);
		check(nm, rd, e);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	// Ramp is one LSB per ten cycles, so the wait scales with distance
	task automatic settle(input string nm, input logic [23:0] e);
		for (int i = 0; i < 20000 && dac_reference !== e; i++) @(negedge clk);
		check(nm, dac_reference, e);
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#800us;
		bad_count++;
		end_sim();
	end
	initial begin
		{reset_n, pgood_pin_is_reset, fault_restore_select, strap_source_select} = 4'h0;
		{restore_user_all, conversion_enabled, fault_shutdown, margin_active} = 4'h0;
		{reset_event, backchannel_event, sync_event, clear_status} = 4'h0;
		power_good_or_reset_pin = 1'b1;
		{nvm_format, nvm_trim, nvm_alert_mask} = {8'h14, 8'h10, 8'hF8};
		{voltage_select_strap, nvm_setpoint, margin_setpoint} = {16'h0025, 16'h0020, 16'h0000};
		{vout_max, vout_min} = {16'hFFFF, 16'h0000};
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		repeat (5) @(negedge clk);
		foreach (rows[i]) begin
			wr(rows[i].cmd, rows[i].wn, rows[i].wd);
			check("ack", ok, 1'b1);
			rdc("readback", rows[i].cmd, rows[i].rn, rows[i].ex);
		end
		$display("table done");
		// Mid-run reset reloads every default
		reset_n = 1'b0;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		repeat (5) @(negedge clk);
		check("trim backup", trim_backup, 8'h10);
		rdc("format", CMD_FORMAT, 1, 16'h0014);
		rdc("setpoint", CMD_SETPOINT, 2, 16'h0020);
		rdc("mask", CMD_ALERT_MASK, 1, 16'h0008);
		pulse(reset_event);
		check("status", vendor_status_byte, 8'h08);
		check("alert", smb_alert_oe, 1'b0);
		pulse(backchannel_event);
		pulse(sync_event);
		check("status", vendor_status_byte, 8'h0E);
		check("alert", smb_alert_oe, 1'b1);
		pulse(clear_status);
		check("alert", smb_alert_oe, 1'b0);
		$display("reset and events done");
		conversion_enabled = 1'b1;
		wr(CMD_FORMAT, 1, 16'h0015);
		rdc("format", CMD_FORMAT, 1, 16'h0014);
		conversion_enabled = 1'b0;
		wr(CMD_FORMAT, 1, 16'h0015);
		rdc("setpoint", CMD_SETPOINT, 2, 16'h0010);
		wr(CMD_SETPOINT, 2, 16'h0011);
		wr(CMD_FORMAT, 1, 16'h0014);
		rdc("setpoint", CMD_SETPOINT, 2, 16'h0022);
		wr(CMD_SETPOINT, 2, 16'h0033);
		pulse(fault_shutdown);
		rdc("setpoint", CMD_SETPOINT, 2, 16'h0033);
		fault_restore_select = 1'b1;
		pulse(fault_shutdown);
		rdc("setpoint", CMD_SETPOINT, 2, 16'h0020);
		wr(CMD_SETPOINT, 2, 16'h0033);
		pgood_pin_is_reset = 1'b1;
		power_good_or_reset_pin = 1'b0;
		repeat (4) @(negedge clk);
		power_good_or_reset_pin = 1'b1;
		repeat (4) @(negedge clk);
		rdc("setpoint", CMD_SETPOINT, 2, 16'h0020);
		strap_source_select = 1'b1;
		pulse(restore_user_all);
		rdc("setpoint", CMD_SETPOINT, 2, 16'h0025);
		wr(CMD_OFFSET, 2, 16'h0200);
		check("trim backup", trim_backup, 8'h7F);
		wr(CMD_OFFSET, 2, 16'hFF00);
		check("trim backup", trim_backup, 8'h80);
		$display("format and defaults done");
		{vout_max, vout_min, conversion_enabled} = {16'h0040, 16'h0010, 1'b1};
		wr(CMD_OFFSET, 2, 16'h0020);
		wr(CMD_SETPOINT, 2, 16'h0030);
		settle("dac at max", 24'h00_0040);
		check("warning", vout_limit_warning, 1'b1);
		check("alert", smb_alert_oe, 1'b1);
		margin_active = 1'b1;
		settle("dac margin", 24'h00_0020);
		wr(CMD_OFFSET, 2, 16'hFFF0);
		settle("dac at min", 24'h00_0010);
		$display("limits done");
		end_sim();
	end
endmodule
`default_nettype wire
